/* File: lpm_ctrl.v */
/*
 enable, shutdown, dimming and pump gain mode control of a three channel led driver.
 assumes all inputs synchronous to clock; undervoltage and regulation flags come from analog comparators.
*/
// Notes on behaviour
// - first rise of enable from shutdown enables device at full-scale current
// - enable low continuously 1.5ms forces shutdown; host must hold it that long
// - undervoltage forces shutdown and disables all channels regardless of enable
// - in shutdown all three led sinks are high impedance, zero current
// - in shutdown the current-set pin is released to high impedance
// - after power-up the pump starts in 1x mode
// - while regulation is met and supply is not sufficient for 1x, mode stays unchanged
// - failing regulation in 1x steps to 1.33x after 120us filter
// - same delayed step 1.33x to 1.5x to 2x; 2x is top
// - sufficient supply returns directly to 1x from any mode
// - each enable rising edge while enabled lowers current by one thirty-first step
// - thirty-first pulse gives zero current, next wraps to full scale
// - lows shorter than 200ns are filtered and ignored
`timescale 1ns/1ps
`include "lpm_defines.vh"
module lpm_ctrl #(
	parameter SHDN_CYC = `LPM_SHDN_CYC,
	parameter FILT_CYC = `LPM_FILT_CYC
) (
	input wire clock,
	input wire sys_rst,
	input wire enable_dimming_input,
	input wire uvlo_active,
	input wire regulation_ok,
	input wire supply_sufficient_1x,
	output reg [1:0] pump_mode_ff,
	output reg [4:0] dim_level_ff,
	output reg device_enabled_ff,
	output reg led_sink_output_a_oe_ff,
	output reg led_sink_output_b_oe_ff,
	output reg led_sink_output_c_oe_ff,
	output reg current_set_resistor_pin_oe_ff
);
	localparam ST_SHDN = 1'b0;
	localparam ST_RUN = 1'b1;

	reg state_ff;
	reg nxt_state;
	reg [1:0] nxt_pump_mode;
	reg [4:0] nxt_dim_level;
	wire en_level;
	wire en_rise;
	wire shdn_done;
	wire filt_done;
	wire filt_run;

	// low-time filter on the wire
	lpm_pulse_filter #(
		.MIN_LOW(`LPM_TLO_MIN_CYC)
	) u_filter (
		.clock(clock),
		.sys_rst(sys_rst),
		.raw_in(enable_dimming_input),
		.level_ff(en_level),
		.rise_ff(en_rise)
	);

	// long low detector
	lpm_timer #(
		.WIDTH(24),
		.LIMIT(SHDN_CYC[23:0])
	) u_shdn_timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.run(!enable_dimming_input && state_ff == ST_RUN),
		.done_ff(shdn_done)
	);

	// mode filter, runs only while enabled and out of regulation
	assign filt_run = (state_ff == ST_RUN) && !uvlo_active && !regulation_ok && !supply_sufficient_1x &&
		(pump_mode_ff != `LPM_MODE_2X) && !filt_done;
	lpm_timer #(
		.WIDTH(16),
		.LIMIT(FILT_CYC[15:0])
	) u_filt_timer (
		.clock(clock),
		.sys_rst(sys_rst),
		.run(filt_run),
		.done_ff(filt_done)
	);

	always @* begin
		nxt_state = state_ff;
		nxt_pump_mode = pump_mode_ff;
		nxt_dim_level = dim_level_ff;
		case (state_ff)
			ST_SHDN: begin
				if (en_rise && !uvlo_active) begin
					nxt_state = ST_RUN;
					nxt_pump_mode = `LPM_MODE_1X;
					nxt_dim_level = `LPM_DIM_FULL;
				end
			end
			ST_RUN: begin
				if (uvlo_active || shdn_done) begin
					nxt_state = ST_SHDN;
				end else begin
					if (en_rise)
						nxt_dim_level = (dim_level_ff == `LPM_DIM_ZERO) ? `LPM_DIM_FULL :
							dim_level_ff + 5'h01;
					if (supply_sufficient_1x)
						nxt_pump_mode = `LPM_MODE_1X;
					else if (filt_done && !regulation_ok && pump_mode_ff != `LPM_MODE_2X)
						nxt_pump_mode = pump_mode_ff + 2'h1;
					// regulation met: no change
				end
			end
			default: begin
				nxt_state = ST_SHDN;
			end
		endcase
	end

	always @(posedge clock) begin
		if (sys_rst) begin
			state_ff <= ST_SHDN;
			pump_mode_ff <= `LPM_MODE_1X;
			dim_level_ff <= `LPM_DIM_FULL;
			device_enabled_ff <= 1'b0;
			led_sink_output_a_oe_ff <= 1'b0;
			led_sink_output_b_oe_ff <= 1'b0;
			led_sink_output_c_oe_ff <= 1'b0;
			current_set_resistor_pin_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pump_mode_ff <= nxt_pump_mode;
			dim_level_ff <= nxt_dim_level;
			device_enabled_ff <= nxt_state;
			led_sink_output_a_oe_ff <= nxt_state;
			led_sink_output_b_oe_ff <= nxt_state;
			led_sink_output_c_oe_ff <= nxt_state;
			current_set_resistor_pin_oe_ff <= nxt_state;
		end
	end
endmodule

/* File: lpm_defines.vh */
/*
 defines for the led pump mode and enable controller: timing, mode codes,
 dimming counter limits. assumes a 20 MHz system clock.
*/
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH
`define LPM_CLK_HZ 20000000
`define LPM_SHDN_TIME_US 1500
`define LPM_SHDN_CYC ((`LPM_SHDN_TIME_US * (`LPM_CLK_HZ / 1000000)))
`define LPM_FILT_TIME_US 120
`define LPM_FILT_CYC ((`LPM_FILT_TIME_US * (`LPM_CLK_HZ / 1000000)))
`define LPM_TLO_MIN_NS 200
`define LPM_TLO_MIN_CYC ((`LPM_TLO_MIN_NS * (`LPM_CLK_HZ / 1000000) + 999) / 1000)
`define LPM_MODE_1X 2'h0
`define LPM_MODE_1P33X 2'h1
`define LPM_MODE_1P5X 2'h2
`define LPM_MODE_2X 2'h3
`define LPM_DIM_FULL 5'h00
`define LPM_DIM_ZERO 5'h1F
`endif

/* File: lpm_timer.v */
/*
 saturating cycle counter with a terminal flag.
 assumes run is synchronous to clock; clearing run restarts the count.
*/
`timescale 1ns/1ps
module lpm_timer #(
	parameter WIDTH = 16,
	parameter [WIDTH-1:0] LIMIT = 16'h0001
) (
	input wire clock,
	input wire sys_rst,
	input wire run,
	output reg done_ff
);
	reg [WIDTH-1:0] cnt_ff;
	always @(posedge clock) begin
		if (sys_rst || !run) begin
			cnt_ff <= {WIDTH{1'b0}};
			done_ff <= 1'b0;
		end else if (cnt_ff != LIMIT) begin
			cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
			done_ff <= (cnt_ff == LIMIT - {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end
endmodule

/* File: lpm_pulse_filter.v */
/*
 low-time filter for the enable/dimming wire.
 assumes the input is synchronous; a low shorter than MIN_LOW cycles is ignored.
*/
`timescale 1ns/1ps
module lpm_pulse_filter #(
	parameter MIN_LOW = 4
) (
	input wire clock,
	input wire sys_rst,
	input wire raw_in,
	output reg level_ff,
	output reg rise_ff
);
	reg [7:0] low_cnt_ff;
	always @(posedge clock) begin
		if (sys_rst) begin
			level_ff <= 1'b0;
			rise_ff <= 1'b0;
			low_cnt_ff <= 8'h00;
		end else begin
			rise_ff <= 1'b0;
			if (raw_in) begin
				low_cnt_ff <= 8'h00;
				if (!level_ff) begin
					level_ff <= 1'b1;
					rise_ff <= 1'b1;
				end
			end else if (low_cnt_ff != 8'hFF) begin
				low_cnt_ff <= low_cnt_ff + 8'h01;
				if (low_cnt_ff == MIN_LOW[7:0] - 8'h01)
					level_ff <= 1'b0;
			end
		end
	end
endmodule

/* File: lpm_host.sv */
/* host model driving the enable/dimming wire
 assumes one clock; changes land 1ns after an edge */
`timescale 1ns/1ps
module lpm_host (
	input wire clock,
	output reg en
);
	initial en = 1'b0;
	// level v for n cycles; no minimum on n, lows of 2 cycles are driven
	task automatic hold(input bit v, input int n);
		@(posedge clock) #1 en = v;
		repeat (n - 1) @(posedge clock);
		#1;
	endtask
endmodule

/* File: lpm_ctrl_checker.sv */
/* port checker of lpm_ctrl
 bound into lpm_ctrl; one clock, sync reset */
`timescale 1ns/1ps
module lpm_ctrl_checker #(parameter FILT_CYC = 20) (
	input wire clock,
	input wire sys_rst,
	input wire uvlo_active,
	input wire regulation_ok,
	input wire supply_sufficient_1x,
	input wire [1:0] pump_mode_ff,
	input wire [4:0] dim_level_ff,
	input wire device_enabled_ff,
	input wire led_sink_output_a_oe_ff,
	input wire current_set_resistor_pin_oe_ff
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_uv; uvlo_active |-> ##[0:3] !device_enabled_ff; endproperty
	a_uv: assert property (p_uv) else $error("on in undervoltage");
	property p_snk; !device_enabled_ff [*3] |-> !led_sink_output_a_oe_ff; endproperty
	a_snk: assert property (p_snk) else $error("sink driven");
	property p_set; !device_enabled_ff [*3] |-> !current_set_resistor_pin_oe_ff; endproperty
	a_set: assert property (p_set) else $error("set pin driven");
	property p_wake; $rose(device_enabled_ff) |-> ##[0:1] pump_mode_ff == 2'h0 && dim_level_ff == 5'h00; endproperty
	a_wake: assert property (p_wake) else $error("bad wake state");
	property p_step; $changed(pump_mode_ff) && pump_mode_ff != 2'h0 |-> pump_mode_ff == $past(pump_mode_ff) + 2'h1;
	endproperty
	a_step: assert property (p_step) else $error("bad mode step");
	property p_filt; $changed(pump_mode_ff) && pump_mode_ff != 2'h0 |-> $past(!regulation_ok, FILT_CYC); endproperty
	a_filt: assert property (p_filt) else $error("step too early");
	property p_down; supply_sufficient_1x && device_enabled_ff |=> pump_mode_ff == 2'h0; endproperty
	a_down: assert property (p_down) else $error("no return to 1x");
	property p_dim; $changed(dim_level_ff) && device_enabled_ff && $past(device_enabled_ff, 2)
		|-> dim_level_ff == $past(dim_level_ff) + 5'h01; endproperty
	a_dim: assert property (p_dim) else $error("bad dim step");
endmodule
bind lpm_ctrl lpm_ctrl_checker #(.FILT_CYC(FILT_CYC)) lpm_ctrl_checker_inst (.clock(clock), .sys_rst(sys_rst),
	.uvlo_active(uvlo_active), .regulation_ok(regulation_ok), .supply_sufficient_1x(supply_sufficient_1x),
	.pump_mode_ff(pump_mode_ff), .dim_level_ff(dim_level_ff), .device_enabled_ff(device_enabled_ff),
	.led_sink_output_a_oe_ff(led_sink_output_a_oe_ff),
	.current_set_resistor_pin_oe_ff(current_set_resistor_pin_oe_ff));

/* File: tb.sv */
/* self-checking bench of lpm_ctrl
 host model drives the enable wire; short counts */
`timescale 1ns/1ps
module tb;
	localparam int FI = 20;
	logic clock = 0, sys_rst = 1, uv = 0, rok = 1, suf = 0;
	wire en, on, oa, ob, oc, os;
	wire [1:0] mode;
	wire [4:0] dim;
	int fails = 0, comparisons = 0;
	lpm_host lpm_host_inst (.clock(clock), .en(en));
	lpm_ctrl #(.SHDN_CYC(50), .FILT_CYC(FI)) lpm_ctrl_inst (.clock(clock), .sys_rst(sys_rst),
		.enable_dimming_input(en), .uvlo_active(uv), .regulation_ok(rok), .supply_sufficient_1x(suf),
		.pump_mode_ff(mode), .dim_level_ff(dim), .device_enabled_ff(on), .led_sink_output_a_oe_ff(oa),
		.led_sink_output_b_oe_ff(ob), .led_sink_output_c_oe_ff(oc), .current_set_resistor_pin_oe_ff(os));
	initial forever #25 clock = ~clock;
	task automatic complete_run;
		if (fails == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [4:0] e, input logic [4:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_on(input logic v);
		for (int i = 0; i < 200 && on !== v; i++) cyc(1);
		if (on !== v) begin
			fails++;
			complete_run;
		end
	endtask
	task automatic t_wake;
		cmp("mode", 0, mode);
		cmp("sinks", 0, {oa, ob, oc, os});
		lpm_host_inst.hold(1, 2);
		wait_on(1);
		cmp("sinks", 5'h0F, {oa, ob, oc, os});
	endtask
	task automatic t_dim;
		for (int i = 1; i < 33; i++) begin
			lpm_host_inst.hold(0, 4);
			lpm_host_inst.hold(1, 4);
			cmp("dim", i, dim);
		end
		lpm_host_inst.hold(0, 2);
		lpm_host_inst.hold(1, 4);
		cmp("dim", 0, dim);
	endtask
	task automatic t_mode;
		logic [1:0] held;
		rok = 0;
		for (int i = 0; i < 200 && mode !== 2'h3; i++) cyc(1);
		cyc(FI + 5);
		cmp("mode", 3, mode);
		suf = 1;
		cyc(2);
		cmp("mode", 0, mode);
		suf = 0;
		cyc(FI + 8);
		uv = 1;
		wait_on(0);
		cmp("sinks", 0, {oa, ob, oc, os});
		held = mode;
		cyc(FI + 5);
		cmp("mode", held, mode);
		uv = 0;
		rok = 1;
		lpm_host_inst.hold(0, 4);
		lpm_host_inst.hold(1, 2);
		wait_on(1);
		cmp("mode", 0, mode);
	endtask
	initial begin
		cyc(2);
		sys_rst = 0;
		t_wake;
		t_dim;
		t_mode;
		lpm_host_inst.hold(0, 4);
		wait_on(0);
		cmp("set pin", 0, os);
		complete_run;
	end
endmodule
